/* File: src/dsk_pkg.sv */
`default_nettype none
package dsk_pkg;

   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int CLK_MHZ     = 250;
   localparam int STEP_PULSE_NS = 1000;
   localparam int STEP_GAP_US = 3000;
   localparam int BIT_CELL_NS = 2000;
   localparam int WD_PULSE_NS = 250;

   // Least times: round up to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int STEP_PULSE_CYC   = ns_to_cyc(STEP_PULSE_NS);
   localparam int BIT_CELL_CYC     = ns_to_cyc(BIT_CELL_NS);
   localparam int WD_PULSE_CYC     = ns_to_cyc(WD_PULSE_NS);
   localparam int STEP_GAP_CYC_DEF = STEP_GAP_US * CLK_MHZ;

   // ************************************************************
   // Bus and buffer
   // ************************************************************
   localparam int DATA_W     = 32;
   localparam int FIFO_DEPTH = 16;

   // ************************************************************
   // Register offsets (low address byte)
   // ************************************************************
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_STEP  = 8'h04;
   localparam logic [7:0] REG_STAT  = 8'h08;
   localparam logic [7:0] REG_WDATA = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;

   // ************************************************************
   // Control fields
   // ************************************************************
   localparam int CTRL_SEL   = 0;
   localparam int CTRL_MOTOR = 1;
   localparam int CTRL_OUTER = 2;
   localparam int CTRL_HEAD1 = 3;
   localparam int CTRL_HD144 = 4;
   localparam int CTRL_EJECT = 5;
   localparam int CTRL_WRITE = 6;
   localparam int CTRL_READ  = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // ************************************************************
   // Status fields
   // ************************************************************
   localparam int STAT_OUTER  = 0;
   localparam int STAT_WPROT  = 1;
   localparam int STAT_HD     = 2;
   localparam int STAT_DCHG   = 3;
   localparam int STAT_STEPB  = 4;
   localparam int STAT_WRBUSY = 5;
   localparam int STAT_RVALID = 6;
   localparam int STAT_FULL   = 7;
   localparam int STAT_EMPTY  = 8;
   localparam int STAT_EJPEND = 9;
   localparam int STAT_IDXCNT = 16;

   typedef enum logic [2:0] {
      STEP_IDLE  = 3'b001,
      STEP_PULSE = 3'b010,
      STEP_GAP   = 3'b100
   } dsk_step_t;

endpackage : dsk_pkg
`default_nettype wire

/* File: src/dsk_fifo.sv */
`default_nettype none
module dsk_fifo #(
   parameter int unsigned WIDTH = 32,          // word width
   parameter int unsigned DEPTH = 16           // words, power of two
) (
   input  wire logic             sys_clk_in,    // system clock
   input  wire logic             arst_n_in,     // async reset, low
   input  wire logic             in_valid_in,   // push request
   output logic                  in_ready_out,  // room for a word
   input  wire logic [WIDTH-1:0] in_data_in,    // pushed word
   output logic                  out_valid_out, // word available
   input  wire logic             out_ready_in,  // pop request
   output logic      [WIDTH-1:0] out_data_out   // head word
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } dsk_fifo_state_t;

   dsk_fifo_state_t q;
   dsk_fifo_state_t d;
   logic [AW:0]     count;

   // Extra pointer bit tells full from empty
   assign count         = q.wp - q.rp;
   assign in_ready_out  = (count != (AW+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign out_data_out  = q.mem[q.rp[AW-1:0]];

   always_comb begin
      d = q;
      if (in_valid_in && in_ready_out) begin
         d.mem[q.wp[AW-1:0]] = in_data_in;
         d.wp = q.wp + 1'b1;
      end
      if (out_ready_in && out_valid_out) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   fifo_no_overrun_a: assert property (
      in_valid_in && !in_ready_out && !out_ready_in |=> $stable(count))
      else $error("fifo accepted a word while full");
   fifo_count_bound_a: assert property (count <= (AW+1)'(DEPTH))
      else $error("fifo count beyond depth");

endmodule : dsk_fifo
`default_nettype wire

/* File: src/dsk_host_ctrl.sv */
// Summary of operation
// - Host selects the unit first; drive answers only while selected. The host drives eject_n_out without waiting for select.
// - Seek sense high moves outward, low inward; drive obeys it.
// - Host puts serial write data out only while write gate is low.
// - Media change flag low after change; cleared by a step pulse to a selected drive with a disk in.
`default_nettype none
module dsk_host_ctrl #(
   parameter int unsigned STEP_GAP_CYC = dsk_pkg::STEP_GAP_CYC_DEF // gap
) (
   input  wire logic                       sys_clk_in,  // 250 MHz clock
   input  wire logic                       arst_n_in,   // async reset, low
   input  wire logic                       hsel_in,     // AHB select
   input  wire logic [31:0]                haddr_in,    // AHB address
   input  wire logic [1:0]                 htrans_in,   // AHB transfer
   input  wire logic                       hwrite_in,   // AHB write
   input  wire logic [2:0]                 hsize_in,    // AHB size
   input  wire logic [dsk_pkg::DATA_W-1:0] hwdata_in,   // AHB write data
   input  wire logic                       hready_in,   // AHB bus ready
   output logic                            hreadyout_out, // AHB ready
   output logic                            hresp_out,   // AHB response
   output logic      [dsk_pkg::DATA_W-1:0] hrdata_out,  // AHB read data
   output logic                            drive_sel_n_out,  // unit select
   output logic                            motor_on_n_out,   // spindle on
   output logic                            direction_out,    // 1 = outward
   output logic                            step_n_out,       // head move
   output logic                            write_gate_n_out, // write enable
   output logic                            write_data_n_out, // write pulses
   output logic                            head_sel_out,     // 0 = head 1
   output logic                            density_mode_out, // 1 = 1.44 MB
   output logic                            eject_n_out,      // eject request
   input  wire logic                       index_n_in,       // rotation mark
   input  wire logic                       outer_track_n_in, // cylinder zero
   input  wire logic                       write_prot_n_in,  // protected
   input  wire logic                       high_density_n_in, // HD media
   input  wire logic                       read_data_n_in,   // read pulses
   input  wire logic                       disk_change_n_in  // media changed
);
   import dsk_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [7:0]  ctrl;
      logic        ph_valid;
      logic        ph_write;
      logic [7:0]  ph_addr;
      logic [31:0] hrdata;
      dsk_step_t   step_st;
      logic [19:0] step_cnt;
      logic        step_req;
      logic        dir;
      logic [8:0]  cell_cnt;
      logic        writing;
      logic [31:0] wshift;
      logic [5:0]  wbits;
      logic [6:0]  wd_cnt;
      logic        rd_prev;
      logic        rseen;
      logic [31:0] rshift;
      logic [4:0]  rbits;
      logic [31:0] rword;
      logic        rvalid;
      logic        idx_prev;
      logic [15:0] idx_count;
   } dsk_state_t;

   localparam dsk_state_t ST_RST = '{
      ctrl: CTRL_RST, step_st: STEP_IDLE, rd_prev: 1'b1,
      idx_prev: 1'b1, default: '0};

   dsk_state_t  q;
   dsk_state_t  d;
   logic        acc;
   logic        wdata_ph;
   logic        rdy;
   logic        cell_tick;
   logic        wr_ok;
   logic        rd_on;
   logic        rd_fall;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [31:0] fifo_out_data;
   logic [31:0] stat_word;

   assign acc       = hsel_in && htrans_in[1] && hready_in;
   assign wdata_ph  = q.ph_valid && q.ph_write && (q.ph_addr == REG_WDATA);
   // Full buffer stalls the bus until the serialiser drains a word
   assign rdy       = !(wdata_ph && !fifo_in_ready);
   assign cell_tick = (q.cell_cnt == 9'(BIT_CELL_CYC - 1));
   // Writing needs select, write mode and an unprotected disk
   assign wr_ok     = q.ctrl[CTRL_SEL] && q.ctrl[CTRL_WRITE]
                      && write_prot_n_in;
   assign rd_on     = q.ctrl[CTRL_SEL] && q.ctrl[CTRL_READ]
                      && !q.writing;
   assign rd_fall   = q.rd_prev && !read_data_n_in;
   assign fifo_out_ready = wr_ok && cell_tick && (q.wbits == '0);

   // Status is only trusted from a selected drive
   always_comb begin
      stat_word = '0;
      stat_word[STAT_OUTER]  = q.ctrl[CTRL_SEL] && !outer_track_n_in;
      stat_word[STAT_WPROT]  = q.ctrl[CTRL_SEL] && !write_prot_n_in;
      stat_word[STAT_HD]     = q.ctrl[CTRL_SEL] && !high_density_n_in;
      stat_word[STAT_DCHG]   = q.ctrl[CTRL_SEL] && !disk_change_n_in;
      stat_word[STAT_STEPB]  = (q.step_st != STEP_IDLE) || q.step_req;
      stat_word[STAT_WRBUSY] = q.writing;
      stat_word[STAT_RVALID] = q.rvalid;
      stat_word[STAT_FULL]   = !fifo_in_ready;
      stat_word[STAT_EMPTY]  = !fifo_out_valid;
      stat_word[STAT_EJPEND] = q.ctrl[CTRL_EJECT] && q.writing;
      stat_word[STAT_IDXCNT +: 16] = q.idx_count;
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic wbit;
      wbit = 1'b0;
      d = q;

      // Bus slave: data phase writes, address phase reads
      if (q.ph_valid && q.ph_write && rdy) begin
         case (q.ph_addr)
            REG_CTRL: d.ctrl     = hwdata_in[7:0];
            default:  ;
         endcase
      end
      if (rdy) begin
         d.ph_valid = acc;
         d.ph_write = hwrite_in;
         d.ph_addr  = haddr_in[7:0];
      end
      if (acc && !hwrite_in) begin
         case (haddr_in[7:0])
            REG_CTRL:  d.hrdata = {24'h00_0000, q.ctrl};
            REG_STAT:  d.hrdata = stat_word;
            REG_RDATA: d.hrdata = q.rword;
            default:   d.hrdata = 32'h0000_0000;
         endcase
         if (haddr_in[7:0] == REG_RDATA) begin
            d.rvalid = 1'b0;
         end
      end

      // Head move sequencer; sense latched for the whole move
      case (q.step_st)
         STEP_IDLE: begin
            d.dir = q.ctrl[CTRL_OUTER];
            if (q.step_req && q.ctrl[CTRL_SEL]) begin
               d.step_req = 1'b0;
               d.step_st  = STEP_PULSE;
               d.step_cnt = 20'(STEP_PULSE_CYC - 1);
            end
         end
         STEP_PULSE: begin
            if (q.step_cnt == '0) begin
               d.step_st  = STEP_GAP;
               d.step_cnt = 20'(STEP_GAP_CYC - 1);
            end else begin
               d.step_cnt = q.step_cnt - 1'b1;
            end
         end
         STEP_GAP: begin
            if (q.step_cnt == '0) begin
               d.step_st = STEP_IDLE;
            end else begin
               d.step_cnt = q.step_cnt - 1'b1;
            end
         end
         default: d.step_st = STEP_IDLE;
      endcase
      if (q.ph_valid && q.ph_write && rdy && (q.ph_addr == REG_STEP)) begin
         d.step_req = 1'b1;
      end

      // Bit cell divider shared by writer and reader
      d.cell_cnt = cell_tick ? 9'h000 : q.cell_cnt + 1'b1;

      // Serial writer, MSB first, one pulse per set bit
      if (q.wd_cnt != '0) begin
         d.wd_cnt = q.wd_cnt - 1'b1;
      end
      if (!wr_ok) begin
         d.writing = 1'b0;
         d.wbits   = '0;
         d.wd_cnt  = '0;
      end else if (cell_tick) begin
         if (q.wbits != '0) begin
            wbit      = q.wshift[31];
            d.wshift  = {q.wshift[30:0], 1'b0};
            d.wbits   = q.wbits - 1'b1;
            d.writing = 1'b1;
         end else if (fifo_out_valid) begin
            wbit      = fifo_out_data[31];
            d.wshift  = {fifo_out_data[30:0], 1'b0};
            d.wbits   = 6'd31;
            d.writing = 1'b1;
         end else begin
            d.writing = 1'b0;
         end
         if (wbit) begin
            d.wd_cnt = 7'(WD_PULSE_CYC);
         end
      end

      // Serial reader: a pulse inside a cell is a one
      d.rd_prev = read_data_n_in;
      if (!rd_on) begin
         d.rseen = 1'b0;
         d.rbits = '0;
      end else begin
         if (rd_fall) begin
            d.rseen = 1'b1;
         end
         if (cell_tick) begin
            d.rshift = {q.rshift[30:0], q.rseen || rd_fall};
            d.rseen  = 1'b0;
            d.rbits  = q.rbits + 1'b1;
            if (q.rbits == 5'd31) begin
               d.rword  = {q.rshift[30:0], q.rseen || rd_fall};
               d.rvalid = 1'b1;
            end
         end
      end

      // Revolutions seen on the rotation marker
      d.idx_prev = index_n_in;
      if (q.idx_prev && !index_n_in && q.ctrl[CTRL_SEL]) begin
         d.idx_count = q.idx_count + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // Write buffer
   // ************************************************************
   dsk_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) dsk_fifo_inst (
      .sys_clk_in    (sys_clk_in),
      .arst_n_in     (arst_n_in),
      .in_valid_in   (wdata_ph),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (hwdata_in),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready),
      .out_data_out  (fifo_out_data)
   );

   // ************************************************************
   // Outputs
   // ************************************************************
   assign hreadyout_out    = rdy;
   assign hresp_out        = 1'b0;
   assign hrdata_out       = q.hrdata;
   assign drive_sel_n_out  = !q.ctrl[CTRL_SEL];
   assign motor_on_n_out   = !(q.ctrl[CTRL_SEL] && q.ctrl[CTRL_MOTOR]);
   assign direction_out    = q.dir;
   assign step_n_out       = (q.step_st != STEP_PULSE);
   assign write_gate_n_out = !(q.writing && q.ctrl[CTRL_SEL]);
   assign write_data_n_out = !((q.wd_cnt != '0) && q.writing
                               && q.ctrl[CTRL_SEL]);
   assign head_sel_out     = !q.ctrl[CTRL_HEAD1];
   assign density_mode_out = q.ctrl[CTRL_HD144];
   // Eject held back while a write runs
   assign eject_n_out      = !(q.ctrl[CTRL_EJECT] && !q.writing);

   // ************************************************************
   // Checks
   // ************************************************************
   localparam int STEP_W_M1 = STEP_PULSE_CYC - 1;
   localparam int WD_W_M1   = WD_PULSE_CYC - 1;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   sequence s_step_low;
      ##STEP_W_M1 !step_n_out ##1 step_n_out;
   endsequence
   sequence s_wd_low;
      ##WD_W_M1 !write_data_n_out ##1 write_data_n_out;
   endsequence

   motor_needs_sel_a: assert property (
      !motor_on_n_out |-> !drive_sel_n_out)
      else $error("motor on without select");
   step_needs_sel_a: assert property (
      $fell(step_n_out) |-> !drive_sel_n_out && $past(!drive_sel_n_out))
      else $error("step issued to unselected drive");
   step_width_a: assert property (
      $fell(step_n_out) |-> s_step_low)
      else $error("step pulse width wrong");
   dir_stable_a: assert property (
      !step_n_out |-> $stable(direction_out))
      else $error("direction moved during step");
   gate_allowed_a: assert property (
      !write_gate_n_out |-> !drive_sel_n_out && $past(write_prot_n_in))
      else $error("write gate on without select or protected");
   wdata_in_gate_a: assert property (
      !write_data_n_out |-> !write_gate_n_out)
      else $error("write data outside write gate");
   wd_width_a: assert property (
      $fell(write_data_n_out) && wr_ok |-> s_wd_low or
      (##[1:62] write_gate_n_out))
      else $error("write pulse width wrong");
   eject_after_write_a: assert property (
      !eject_n_out |-> write_gate_n_out)
      else $error("eject during write");
   rvalid_set_wins_a: assert property (
      rd_on && cell_tick && q.rbits == 5'd31 |=> q.rvalid)
      else $error("read word lost");

endmodule : dsk_host_ctrl
`default_nettype wire

/* File: tb/dsk_drive_model.sv */
`default_nettype none
module dsk_drive_model #(
   parameter int IDX_CYC  = 1000, // cycles per revolution
   parameter int CELL_CYC = 500   // cycles per bit cell
) (
   input  wire logic sys_clk_in,         // clock
   input  wire logic drive_sel_n_in,     // unit select
   input  wire logic motor_on_n_in,      // spindle on
   input  wire logic direction_in,       // 1 = outward
   input  wire logic step_n_in,          // head move
   input  wire logic write_gate_n_in,    // write enable
   input  wire logic write_data_n_in,    // write pulses
   input  wire logic head_sel_in,        // 0 = head 1
   input  wire logic density_mode_in,    // 1 = 1.44 MB
   input  wire logic eject_n_in,         // eject request
   output logic      index_n_out,        // rotation mark
   output logic      outer_track_n_out,  // cylinder zero
   output logic      write_prot_n_out,   // protected
   output logic      high_density_n_out, // HD media
   output logic      read_data_n_out,    // read pulses
   output logic      disk_change_n_out   // media changed
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cyl = 0, idx_t = 0, rd_t = 0, wd_cnt = 0, bad = 0;
   logic present = 1'b1, wprot = 1'b0, hd = 1'b1, chg = 1'b1;
   logic step_q = 1'b1, wd_q = 1'b1, head_one, hd_mode;
   wire  sel = !drive_sel_n_in;
   // ****************************************
   // Pins; released lines sit at pull-up level
   // ****************************************
   assign head_one = !head_sel_in;
   assign hd_mode = density_mode_in;
   assign index_n_out = !(sel && !motor_on_n_in && idx_t >= IDX_CYC - 4);
   assign outer_track_n_out = !(sel && cyl == 0);
   assign write_prot_n_out = !(sel && wprot);
   assign high_density_n_out = !(sel && present && hd);
   assign disk_change_n_out = !(sel && chg);
   // All-ones pulses: cell phase of the host does not matter
   assign read_data_n_out =
      !(sel && present && write_gate_n_in && rd_t < 8);
   always @(posedge sys_clk_in) begin
      step_q <= step_n_in;
      wd_q <= write_data_n_in;
      rd_t <= (rd_t == CELL_CYC - 1) ? 0 : rd_t + 1;
      if (!motor_on_n_in)
         idx_t <= (idx_t == IDX_CYC - 1) ? 0 : idx_t + 1;
      else
         idx_t <= 0;
      if (sel && step_n_in && !step_q) begin
         if (direction_in) begin
            if (cyl > 0) cyl <= cyl - 1;
         end else
            cyl <= cyl + 1;
         if (present) chg <= 1'b0;
      end
      if (!write_data_n_in && wd_q) begin
         if (write_gate_n_in) bad <= bad + 1;
         else if (sel && !wprot) wd_cnt <= wd_cnt + 1;
      end
      // Ejection waits for the write gate to rise
      if (sel && !eject_n_in && write_gate_n_in && present) begin
         present <= 1'b0;
         chg <= 1'b1;
      end
   end
endmodule // dsk_drive_model
`default_nettype wire

/* File: tb/dsk_host_ctrl_tb.sv */
`default_nettype none
module dsk_host_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dsk_pkg::*;
   localparam logic [31:0] B_SEL = 32'h0000_0001 << CTRL_SEL;
   localparam logic [31:0] B_MOT = 32'h0000_0001 << CTRL_MOTOR;
   localparam logic [31:0] B_OUT = 32'h0000_0001 << CTRL_OUTER;
   localparam logic [31:0] B_HD1 = 32'h0000_0001 << CTRL_HEAD1;
   localparam logic [31:0] B_144 = 32'h0000_0001 << CTRL_HD144;
   localparam logic [31:0] B_EJ  = 32'h0000_0001 << CTRL_EJECT;
   localparam logic [31:0] B_WR  = 32'h0000_0001 << CTRL_WRITE;
   localparam logic [31:0] B_RD  = 32'h0000_0001 << CTRL_READ;
   logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, v;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hready, hresp, sel_n, mot_n, dir, stp_n, wg_n, wd_n;
   logic        hs, dm, ej_n, idx_n, ot_n, wp_n, hd_n, rd_n, dc_n;
   logic [15:0] a;
   int          err_count = 0, num_checks = 0, n;

   dsk_host_ctrl #(.STEP_GAP_CYC(20)) dsk_host_ctrl_inst (
      .sys_clk_in(clk), .arst_n_in(rst_n), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
      .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
      .drive_sel_n_out(sel_n), .motor_on_n_out(mot_n),
      .direction_out(dir), .step_n_out(stp_n), .write_gate_n_out(wg_n),
      .write_data_n_out(wd_n), .head_sel_out(hs),
      .density_mode_out(dm), .eject_n_out(ej_n), .index_n_in(idx_n),
      .outer_track_n_in(ot_n), .write_prot_n_in(wp_n),
      .high_density_n_in(hd_n), .read_data_n_in(rd_n),
      .disk_change_n_in(dc_n));
   dsk_drive_model dsk_drive_model_inst (
      .sys_clk_in(clk), .drive_sel_n_in(sel_n), .motor_on_n_in(mot_n),
      .direction_in(dir), .step_n_in(stp_n), .write_gate_n_in(wg_n),
      .write_data_n_in(wd_n), .head_sel_in(hs), .density_mode_in(dm),
      .eject_n_in(ej_n), .index_n_out(idx_n), .outer_track_n_out(ot_n),
      .write_prot_n_out(wp_n), .high_density_n_out(hd_n),
      .read_data_n_out(rd_n), .disk_change_n_out(dc_n));

   // ****************************************
   // Bus and check tasks
   // ****************************************
   initial forever #2 clk = ~clk;
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] ad,
                      input logic [31:0] d);
      haddr <= {24'h00_0000, ad};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      v = hrdata;
   endtask
   task automatic rd(input logic [7:0] ad);
      ahb(1'b0, ad, 32'h0000_0000);
   endtask
   task automatic wait_stat(input int b, input logic val);
      rd(REG_STAT);
      for (int i = 0; i < 20000 && v[b] !== val; i++) rd(REG_STAT);
      chk("status wait", 32'(v[b]), 32'(val));
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      summarize();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      chk("pins", 32'({sel_n, mot_n, stp_n, wg_n, wd_n, ej_n, hs, dm, hresp}),
          32'h0000_01FC);
      ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
      rd(8'h40);
      chk("unmapped", v, 32'h0000_0000);
      rd(REG_CTRL);
      chk("ctrl", v, 32'h0000_0000);
      rd(REG_STAT);
      chk("released status", 32'(v[3:0]), 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_select;
      ahb(1'b1, REG_CTRL, B_SEL | B_MOT | B_HD1 | B_144);
      @(posedge clk);
      chk("pins", 32'({sel_n, mot_n, hs, dm}), 32'h0000_0001);
      rd(REG_STAT);
      chk("status", 32'(v[3:0]), 32'h0000_000D);
      a = v[31:16];
      repeat (998) @(posedge clk);
      rd(REG_STAT);
      chk("index count", 32'(v[31:16]), 32'(a + 16'h0001));
      $display("test select done");
   endtask
   task automatic t_step;
      for (int i = 0; i < 4; i++) begin
         if (i == 2) ahb(1'b1, REG_CTRL, B_SEL | B_MOT | B_OUT);
         if (i == 0) ahb(1'b1, REG_CTRL, B_SEL | B_MOT);
         ahb(1'b1, REG_STEP, 32'h0000_0000);
         for (n = 0; n < 20 && stp_n !== 1'b0; n++) @(posedge clk);
         for (n = 0; n < 400 && stp_n === 1'b0; n++) @(posedge clk);
         chk("step width", 32'(n), 32'(STEP_PULSE_CYC));
         wait_stat(STAT_STEPB, 1'b0);
         chk("cylinder", 32'(dsk_drive_model_inst.cyl),
             32'((i < 2) ? i + 1 : 3 - i));
         chk("outer", 32'(v[STAT_OUTER]), 32'(i == 3));
      end
      chk("changed", 32'(v[STAT_DCHG]), 32'h0000_0000);
      $display("test step done");
   endtask
   task automatic t_read;
      ahb(1'b1, REG_CTRL, B_SEL | B_MOT | B_RD);
      wait_stat(STAT_RVALID, 1'b1);
      rd(REG_RDATA);
      chk("read word", v, 32'hFFFF_FFFF);
      rd(REG_STAT);
      chk("read valid", 32'(v[STAT_RVALID]), 32'h0000_0000);
      $display("test read done");
   endtask
   task automatic t_write;
      ahb(1'b1, REG_CTRL, B_SEL | B_WR);
      ahb(1'b1, REG_WDATA, 32'h8000_0001);
      for (n = 0; n < 1200 && wg_n !== 1'b0; n++) @(posedge clk);
      ahb(1'b1, REG_CTRL, B_SEL | B_WR | B_EJ);
      repeat (4) @(posedge clk);
      chk("eject held", 32'(ej_n), 32'h0000_0001);
      rd(REG_STAT);
      chk("eject pending", 32'(v[STAT_EJPEND]), 32'h0000_0001);
      wait_stat(STAT_WRBUSY, 1'b0);
      repeat (4) @(posedge clk);
      chk("write pulses", 32'(dsk_drive_model_inst.wd_cnt), 32'h0000_0002);
      chk("stray pulses", 32'(dsk_drive_model_inst.bad), 32'h0000_0000);
      chk("eject", 32'({ej_n, dsk_drive_model_inst.present}), 32'h0000_0000);
      rd(REG_STAT);
      chk("after eject", 32'(v[3:2]), 32'h0000_0002);
      $display("test write done");
   endtask
   task automatic t_full;
      dsk_drive_model_inst.wprot <= 1'b1;
      ahb(1'b1, REG_CTRL, B_SEL);
      for (int i = 0; i < FIFO_DEPTH; i++)
         ahb(1'b1, REG_WDATA, 32'hFFFF_FFFF);
      rd(REG_STAT);
      chk("fifo full", 32'({v[STAT_FULL], v[STAT_EMPTY], v[STAT_WPROT]}),
          32'h0000_0005);
      ahb(1'b1, REG_CTRL, B_SEL | B_WR);
      repeat (1200) @(posedge clk);
      chk("protected", 32'({wg_n, wd_n}), 32'h0000_0003);
      chk("no writes", 32'(dsk_drive_model_inst.wd_cnt), 32'h0000_0002);
      // Word pushed into a full buffer stalls until the writer pops one
      dsk_drive_model_inst.wprot <= 1'b0;
      ahb(1'b1, REG_WDATA, 32'h0000_0000);
      rd(REG_STAT);
      chk("refill", 32'({v[STAT_FULL], v[STAT_WRBUSY]}), 32'h0000_0003);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      ahb(1'b1, REG_CTRL, B_SEL);
      rd(REG_STAT);
      chk("fifo empty", 32'(v[STAT_EMPTY]), 32'h0000_0001);
      $display("test full done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      t_reset();
      t_select();
      t_step();
      t_read();
      t_write();
      t_full();
      summarize();
   end
endmodule // dsk_host_ctrl_tb
`default_nettype wire
